/* File: bit_set_and_bit_test_skip_exec_bench.sv */
// Self-checking testbench for the bit set and bit test skip executor.
`timescale 1ns/10ps
module bit_set_and_bit_test_skip_exec_bench;
  import bst_pkg::*;

  // ----------------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic en = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic instr_ready;
  logic [1:0] next_words = 2'h0;
  logic [BANK_W-1:0] bank_sel = 6'h00;
  logic ext_en = 1'b0;
  logic [DATA_AW-1:0] idx_base = 14'h0000;
  logic [DATA_AW-1:0] mem_addr;
  logic mem_rd;
  logic [7:0] mem_rdata = 8'h00;
  logic mem_wr;
  logic [7:0] mem_wdata;
  logic [1:0] phase;
  logic skip_nop;
  logic instr_done;
  logic bad_opcode;
  logic [7:0] mem [0:16383];
  int num_errors = 0;
  int num_checks = 0;
  int rd_count, wr_count, nop_count, bad_count;
  logic [DATA_AW-1:0] last_rd_addr, last_wr_addr;
  logic [7:0] last_wr_data;
  logic [1:0] wr_phase;

  bst_exec i_bst_exec (
    .clk(clk), .nrst(nrst), .en(en),
    .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
    .next_words(next_words), .bank_sel(bank_sel), .ext_en(ext_en), .idx_base(idx_base),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .phase(phase), .skip_nop(skip_nop), .instr_done(instr_done),
    .bad_opcode(bad_opcode)
  );

  // Clock of 8 ns period.
  always #4 clk = ~clk;

  // ----------------------------------------------------------------------
  // Data memory model and port monitor
  // ----------------------------------------------------------------------
  // Read data is only valid in the cycle after the strobe; otherwise it flips so
  // that a design sampling at the wrong moment sees garbage.
  always @(posedge clk)
  begin
    if (mem_rd === 1'b1)
    begin
      rd_count++;
      last_rd_addr = mem_addr;
      mem_rdata <= mem[mem_addr];
    end
    else
      mem_rdata <= ~mem_rdata;
    if (mem_wr === 1'b1)
    begin
      wr_count++;
      last_wr_addr = mem_addr;
      last_wr_data = mem_wdata;
      wr_phase = phase;
      mem[mem_addr] <= mem_wdata;
    end
    if (skip_nop === 1'b1)
      nop_count++;
    if (bad_opcode === 1'b1)
      bad_count++;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Expected data address from the access bit, bank and extended mode.
  function automatic logic [13:0] exp_addr(input logic a, input logic [7:0] f,
                                           input logic [5:0] bank, input logic ext,
                                           input logic [13:0] base);
    if (!a && ext && f <= 8'h5f)
      return base + {6'h00, f};
    if (!a)
      return (f < 8'h60) ? {6'h00, f} : {6'h3f, f};
    return {bank, f};
  endfunction

  // Offers one word once the core is idle and counts cycles from take to done.
  task automatic run(input logic [15:0] w, input logic [1:0] nw, output int cyc);
    int k;
    k = 0;
    while (instr_ready !== 1'b1)
    begin
      @(posedge clk);
      #1;
      k++;
      if (k > 50)
      begin
        num_errors++;
        complete_run();
      end
    end
    rd_count = 0;
    wr_count = 0;
    nop_count = 0;
    bad_count = 0;
    instr_valid = 1'b1;
    instr_word = w;
    next_words = nw;
    @(posedge clk);
    #1;
    instr_valid = 1'b0;
    check("ready while busy", instr_ready, 1'b0);
    cyc = 0;
    for (k = 1; k <= 40 && cyc == 0; k++)
    begin
      @(posedge clk);
      #1;
      if (instr_done === 1'b1)
        cyc = k;
    end
    if (cyc == 0)
    begin
      num_errors++;
      complete_run();
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic do_set(input logic [2:0] b, input logic a, input logic [7:0] f,
                        input logic [5:0] bank, input logic ext, input logic [13:0] base);
    logic [13:0] ad;
    logic [7:0] ex;
    int cyc;
    bank_sel = bank;
    ext_en = ext;
    idx_base = base;
    ad = exp_addr(a, f, bank, ext, base);
    ex = mem[ad] | (8'h01 << b);
    run({4'h8, b, a, f}, 2'h0, cyc);
    check("set cycles", cyc, 4);
    check("set writes", wr_count, 1);
    check("set write phase", wr_phase, PH_WRITE);
    check("set read addr", last_rd_addr, ad);
    check("set write addr", last_wr_addr, ad);
    check("set write data", last_wr_data, ex);
  endtask

  task automatic do_test(input logic [2:0] b, input logic a, input logic [7:0] f,
                         input logic ext, input logic [7:0] v, input logic [1:0] nw);
    logic [13:0] ad;
    int n, ec, cyc;
    ext_en = ext;
    bank_sel = 6'h2a;
    idx_base = 14'h0230;
    ad = exp_addr(a, f, 6'h2a, ext, 14'h0230);
    mem[ad] = v;
    n = (nw == 2'h0) ? 1 : int'(nw);
    ec = v[b] ? 0 : 4 * n;
    run({4'hb, b, a, f}, nw, cyc);
    check("test cycles", cyc, 4 + ec);
    check("test nop cycles", nop_count, ec);
    check("test writes", wr_count, 0);
    check("test reads", rd_count, 1);
    check("test read addr", last_rd_addr, ad);
  endtask

  task automatic t_set();
    do_set(3'h7, 1'b1, 8'h12, 6'h05, 1'b0, 14'h0000);
    do_set(3'h0, 1'b0, 8'h20, 6'h05, 1'b0, 14'h0000);
    do_set(3'h3, 1'b0, 8'h60, 6'h05, 1'b0, 14'h0000);
    do_set(3'h5, 1'b0, 8'h5f, 6'h05, 1'b1, 14'h0100);
    do_set(3'h2, 1'b0, 8'h60, 6'h05, 1'b1, 14'h0100);
    do_set(3'h6, 1'b1, 8'h00, 6'h3e, 1'b1, 14'h0100);
    $display("test set done");
  endtask

  task automatic t_test();
    do_test(3'h1, 1'b1, 8'h44, 1'b0, 8'h02, 2'h1);
    do_test(3'h1, 1'b1, 8'h44, 1'b0, 8'hfd, 2'h1);
    do_test(3'h4, 1'b0, 8'h10, 1'b0, 8'hef, 2'h2);
    do_test(3'h7, 1'b0, 8'hf0, 1'b0, 8'h7f, 2'h3);
    do_test(3'h0, 1'b0, 8'h5f, 1'b1, 8'hfe, 2'h0);
    do_test(3'h0, 1'b0, 8'h5f, 1'b1, 8'h01, 2'h3);
    $display("test skip done");
  endtask

  task automatic t_bad();
    int k;
    bad_count = 0;
    wr_count = 0;
    instr_valid = 1'b1;
    instr_word = 16'ha312;
    @(posedge clk);
    #1;
    instr_valid = 1'b0;
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk);
      #1;
    end
    check("bad opcode pulses", bad_count, 1);
    check("bad opcode writes", wr_count, 0);
    $display("test bad opcode done");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 16384; i++)
      mem[i] = i[7:0] ^ 8'h5a;
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_set();
    t_test();
    t_bad();
    complete_run();
  end

endmodule

/* File: bst_addr.sv */
// Data memory address resolver for the bit-oriented instructions.
`timescale 1ns/10ps
module bst_addr
  import bst_pkg::*;
(
  // Instruction fields.
  input wire logic [7:0] file_addr,
  input wire logic access_bit,
  // Core context.
  input wire logic [bst_pkg::BANK_W-1:0] bank_sel,
  input wire logic ext_en,
  input wire logic [bst_pkg::DATA_AW-1:0] idx_base,
  // Result.
  output logic [bst_pkg::DATA_AW-1:0] data_addr,
  output logic indexed
);

  // ----------------------------------------------------------------------
  // Bank resolution
  // ----------------------------------------------------------------------
  // Indexed mode takes priority over the access bank, so it is checked first.
  always_comb
  begin
    indexed = ext_en && !access_bit && (file_addr <= IDX_LIMIT); // [RULE4]
    if (indexed)
    begin
      data_addr = idx_base + {6'h00, file_addr}; // [RULE4]
    end
    else if (access_bit)
    begin
      data_addr = {bank_sel, file_addr}; // [RULE3]
    end
    else if (file_addr < ACC_SPLIT)
    begin
      data_addr = {6'h00, file_addr}; // [RULE2]
    end
    else
    begin
      data_addr = {ACC_HI_BANK, file_addr}; // [RULE2]
    end
  end

endmodule

/* File: bst_exec.sv */
// Executor for the bit set and bit test skip-if-clear instructions.
//
// Summary of operation
// [RULE1] Opcode 1000 bbba ffffffff sets bit b of the addressed register only.
// [RULE2] Access bit zero places the file address in the fixed access bank.
// [RULE3] Access bit one joins the bank select register with the file address.
// [RULE4] Extended set, access bit zero, address up to 95: indexed literal offset.
// [RULE5] Opcode 1011: read register, skip next instruction if bit clear; no flags.
// [RULE6] A skip discards the prefetched word and runs one no-operation cycle.
// [RULE7] Skipping a two-word instruction inserts two no-operation cycles.
// [RULE8] Skipping a three-word instruction inserts three no-operation cycles.
// [RULE9] Bit set: one word, decode, read, modify, write in four phases.
// [RULE10] Bit test: one word, read in phase two, test in three, never writes.
`timescale 1ns/10ps
module bst_exec
  import bst_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  // Instruction handoff.
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  input wire logic [1:0] next_words,
  // Core context.
  input wire logic [bst_pkg::BANK_W-1:0] bank_sel,
  input wire logic ext_en,
  input wire logic [bst_pkg::DATA_AW-1:0] idx_base,
  // Data memory port.
  output logic [bst_pkg::DATA_AW-1:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  // Status.
  output logic [1:0] phase,
  output logic skip_nop,
  output logic instr_done,
  output logic bad_opcode
);
  import bst_pkg::*;

  bst_state_e state_q;
  logic [1:0] phase_q;
  logic [15:0] word_q;
  bst_op_e op_q;
  logic [DATA_AW-1:0] addr_q;
  logic [DATA_AW-1:0] addr_d;
  logic indexed_d;
  logic [7:0] rdata_q;
  logic [7:0] wdata_q;
  logic [7:0] bit_mask;
  logic skip_q;
  logic [1:0] nop_left_q;
  logic done_q;
  logic bad_q;
  logic take;
  logic last_phase;

  // ----------------------------------------------------------------------
  // Handoff
  // ----------------------------------------------------------------------
  // A new word is only taken between instructions; the fetch side must hold it.
  assign instr_ready = en && (state_q == BST_ST_IDLE);
  assign take = instr_ready && instr_valid;
  assign last_phase = (phase_q == PH_WRITE);
  assign phase = phase_q;

  // Address decode is combinational and captured in the decode phase.
  bst_addr i_bst_addr (
    .file_addr(word_q[FA_MSB:FA_LSB]),
    .access_bit(word_q[ACC_POS]),
    .bank_sel(bank_sel),
    .ext_en(ext_en),
    .idx_base(idx_base),
    .data_addr(addr_d),
    .indexed(indexed_d)
  );

  // One-hot mask of the selected bit, built bit by bit.
  generate
    for (genvar i = 0; i < 8; i++)
    begin : g_mask
      assign bit_mask[i] = (word_q[BIT_MSB:BIT_LSB] == 3'(i));
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Phase counter and state advance together; the clock enable freezes both.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= BST_ST_IDLE;
      phase_q <= PH_DECODE;
    end
    else if (en)
    begin
      case (state_q)
        BST_ST_IDLE:
        begin
          phase_q <= PH_DECODE;
          if (take && (bst_op_of(instr_word) != BST_OP_NONE))
          begin
            state_q <= BST_ST_EXEC;
          end
        end
        BST_ST_EXEC:
        begin
          phase_q <= phase_q + 2'h1; // [RULE9] [RULE10]
          if (last_phase)
          begin
            state_q <= skip_q ? BST_ST_NOP : BST_ST_IDLE; // [RULE5]
          end
        end
        BST_ST_NOP:
        begin
          phase_q <= phase_q + 2'h1;
          if (last_phase && (nop_left_q == 2'h1))
          begin
            state_q <= BST_ST_IDLE;
          end
        end
        default:
        begin
          state_q <= BST_ST_IDLE;
          phase_q <= PH_DECODE;
        end
      endcase
    end
  end

  // Instruction capture.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      word_q <= 16'h0000;
      op_q <= BST_OP_NONE;
    end
    else if (en && take)
    begin
      word_q <= instr_word;
      op_q <= bst_op_of(instr_word);
    end
  end

  // Address latched at decode so that a bank change mid-instruction has no effect.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_q <= '0;
    end
    else if (en && (state_q == BST_ST_EXEC) && (phase_q == PH_DECODE))
    begin
      addr_q <= addr_d; // [RULE2] [RULE3] [RULE4]
    end
  end

  // ----------------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------------
  // Read data is sampled in the process phase, one cycle after the read strobe.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= DATA_RESET;
      wdata_q <= DATA_RESET;
      skip_q <= 1'b0;
    end
    else if (en && (state_q == BST_ST_EXEC) && (phase_q == PH_PROCESS))
    begin
      rdata_q <= mem_rdata;
      wdata_q <= mem_rdata | bit_mask; // [RULE1]
      skip_q <= (op_q == BST_OP_TEST) && ((mem_rdata & bit_mask) == 8'h00); // [RULE5]
    end
  end

  // The follower length is taken at test time; zero is treated as one word.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      nop_left_q <= 2'h0;
    end
    else if (en)
    begin
      if ((state_q == BST_ST_EXEC) && (phase_q == PH_PROCESS))
      begin
        nop_left_q <= (next_words == 2'h0) ? 2'h1 : next_words; // [RULE6] [RULE7] [RULE8]
      end
      else if ((state_q == BST_ST_NOP) && last_phase)
      begin
        nop_left_q <= nop_left_q - 2'h1;
      end
    end
  end

  // Completion and refusal pulses, registered for clean timing.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      done_q <= 1'b0;
      bad_q <= 1'b0;
    end
    else if (en)
    begin
      done_q <= last_phase && (((state_q == BST_ST_EXEC) && !skip_q)
                || ((state_q == BST_ST_NOP) && (nop_left_q == 2'h1)));
      bad_q <= take && (bst_op_of(instr_word) == BST_OP_NONE);
    end
    else
    begin
      done_q <= 1'b0;
      bad_q <= 1'b0;
    end
  end

  // Strobes are gated by the enable so nothing repeats while frozen.
  assign mem_addr = addr_q;
  assign mem_rd = en && (state_q == BST_ST_EXEC) && (phase_q == PH_READ); // [RULE9] [RULE10]
  assign mem_wr = en && (state_q == BST_ST_EXEC) && last_phase && (op_q == BST_OP_SET); // [RULE9]
  assign mem_wdata = wdata_q;
  assign skip_nop = (state_q == BST_ST_NOP); // [RULE6]
  assign instr_done = done_q;
  assign bad_opcode = bad_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic ck_acc;
  logic ck_idx;
  logic ck_start;
  assign ck_acc = word_q[ACC_POS];
  assign ck_idx = ext_en && !ck_acc && (word_q[FA_MSB:FA_LSB] <= IDX_LIMIT);
  assign ck_start = (state_q == BST_ST_EXEC) && (phase_q == PH_DECODE) && en;

  sequence s_skip_at(int unsigned w);
    en && (state_q == BST_ST_EXEC) && last_phase && skip_q && (nop_left_q == 2'(w));
  endsequence

  property p_set_write;
    @(posedge clk) disable iff (!nrst || !en)
      mem_wr |-> (mem_wdata == (rdata_q | bit_mask)) && $onehot(mem_wdata ^ rdata_q | bit_mask);
  endproperty
  a_set_write: assert property (p_set_write) else $error("bit set wrote wrong data"); // [RULE1]

  property p_access_bank;
    @(posedge clk) disable iff (!nrst || !en)
      ck_start && !ck_acc && !ext_en |=> mem_addr[7:0] == word_q[7:0]
        && (mem_addr[13:8] == ((word_q[7:0] < ACC_SPLIT) ? 6'h00 : ACC_HI_BANK));
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank address wrong"); // [RULE2]

  property p_bank_sel;
    @(posedge clk) disable iff (!nrst || !en)
      ck_start && ck_acc |=> mem_addr == {$past(bank_sel), word_q[7:0]};
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("banked address wrong"); // [RULE3]

  property p_indexed;
    @(posedge clk) disable iff (!nrst || !en)
      ck_start && ck_idx |=> mem_addr == $past(idx_base) + {6'h00, word_q[7:0]};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong"); // [RULE4]

  property p_skip_decision;
    @(posedge clk) disable iff (!nrst || !en)
      (state_q == BST_ST_EXEC) && (phase_q == PH_PROCESS) && (op_q == BST_OP_TEST)
        && ((mem_rdata & bit_mask) == 8'h00) |=> ##1 skip_nop;
  endproperty
  a_skip_decision: assert property (p_skip_decision) else $error("clear bit did not skip"); // [RULE5]

  property p_one_nop;
    @(posedge clk) disable iff (!nrst || !en)
      s_skip_at(1) |=> skip_nop[*4] ##1 (!skip_nop && instr_done);
  endproperty
  a_one_nop: assert property (p_one_nop) else $error("single skip length wrong"); // [RULE6]

  property p_two_nop;
    @(posedge clk) disable iff (!nrst || !en)
      s_skip_at(2) |=> skip_nop[*8] ##1 (!skip_nop && instr_done);
  endproperty
  a_two_nop: assert property (p_two_nop) else $error("two-word skip length wrong"); // [RULE7]

  property p_three_nop;
    @(posedge clk) disable iff (!nrst || !en)
      s_skip_at(3) |=> skip_nop[*8] ##1 skip_nop[*4] ##1 (!skip_nop && instr_done);
  endproperty
  a_three_nop: assert property (p_three_nop) else $error("three-word skip length wrong"); // [RULE8]

  property p_set_phases;
    @(posedge clk) disable iff (!nrst || !en)
      ck_start && (op_q == BST_OP_SET) |=> mem_rd ##1 !mem_wr ##1 mem_wr ##1 instr_done;
  endproperty
  a_set_phases: assert property (p_set_phases) else $error("bit set phases wrong"); // [RULE9]

  property p_test_no_write;
    @(posedge clk) disable iff (!nrst || !en)
      ck_start && (op_q == BST_OP_TEST) |=> mem_rd ##1 !mem_wr[*2];
  endproperty
  a_test_no_write: assert property (p_test_no_write) else $error("bit test wrote"); // [RULE10]

endmodule

/* File: bst_pkg.sv */
// Package of constants and types for the bit set and bit test skip executor.
package bst_pkg;

  // ----------------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------------
  localparam int unsigned OPC_MSB = 15;
  localparam int unsigned OPC_LSB = 12;
  localparam int unsigned BIT_MSB = 11;
  localparam int unsigned BIT_LSB = 9;
  localparam int unsigned ACC_POS = 8;
  localparam int unsigned FA_MSB = 7;
  localparam int unsigned FA_LSB = 0;
  localparam logic [3:0] OPC_SET_BIT = 4'h8;
  localparam logic [3:0] OPC_TEST_CLR = 4'hb;

  // ----------------------------------------------------------------------
  // Data memory layout
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_AW = 14;
  localparam int unsigned BANK_W = 6;
  localparam logic [7:0] ACC_SPLIT = 8'h60;      // Access bank low part ends below this.
  localparam logic [7:0] IDX_LIMIT = 8'h5f;      // Highest offset that uses indexed mode.
  localparam logic [5:0] ACC_HI_BANK = 6'h3f;    // Bank that holds the upper access part.

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] PH_DECODE = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_PROCESS = 2'h2;
  localparam logic [1:0] PH_WRITE = 2'h3;
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef enum logic [1:0] {
    BST_OP_NONE,
    BST_OP_SET,
    BST_OP_TEST
  } bst_op_e;

  typedef enum {
    BST_ST_IDLE,
    BST_ST_EXEC,
    BST_ST_NOP
  } bst_state_e;

  // Classifies an instruction word; used by the acceptor and the executor.
  function automatic bst_op_e bst_op_of(input logic [15:0] word);
    case (word[OPC_MSB:OPC_LSB])
      OPC_SET_BIT: bst_op_of = BST_OP_SET;
      OPC_TEST_CLR: bst_op_of = BST_OP_TEST;
      default: bst_op_of = BST_OP_NONE;
    endcase
  endfunction

endpackage
